// [hw/wdit_top.sv]
// Watchdog and interval timer with an APB register slave.
//
// Operation
// - Count with a 15-bit counter on the slow oscillator; software cannot read it.
// - Force the counter to zero when either deepest power mode is entered.
// - After system reset the unit is disabled and the counter holds.
// - Mode bit 0 selects watchdog operation, 1 selects interval timer operation.
// - Writing 1 to the enable bit starts the counter incrementing.
// - Once enabled in watchdog mode, writes of 0 to enable are ignored.
// - The counter clock is a 32.768 kHz crystal or 32-36 kHz RC.
// - Interval select picks 64, 512, 8192 or 32768 counter clocks.
// - In watchdog mode reaching the interval asserts the system reset output.
// - Key 1010 then 0101 within half a slow period zeroes the counter.
// - An incomplete clear sequence leaves the counter alone, so reset follows.
// - A sequence started before expiry and finished after it does not clear the counter.
// - Enabled in watchdog mode, mode writes are ignored; interval writes still apply.
// - Watchdog mode never raises an interrupt request.
// - Timer mode sets the interval flag; interrupt only when its enable is 1.
// - In timer mode writing 1 to key bit 0 zeroes the counter.
// - In timer mode enable 0 stops counting, enable 1 restarts from zero.
// - Timer mode never asserts system reset on reaching the interval.
// - In active and lightest sleep the watchdog counts and resets on timeout.
// - In light sleep no reset on timeout; resuming at expiry resets at once.
// - Deep modes stop the unit, keep its setup, and restart counting at zero.
// - Clear key writes have no effect while enable is 0.
`timescale 1ns/10ps
`default_nettype none
module wdit_top
    import wdit_pkg::*;
(
    input  wire logic               clk_sys,
    input  wire logic               reset,
    input  wire logic               ls_osc_in,
    input  wire logic [2:0]         pwr_mode,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    output logic                    sys_reset_out,
    output logic                    irq_out
);

    wdit_state_t  st_reg;
    wdit_state_t  st_next;
    logic         edge_any;
    logic         tick;
    logic         deep;
    logic         may_reset;
    logic         running;
    logic         expire;
    logic         locked;
    logic         take;
    logic         done;
    logic         wr_ctrl;
    logic         wr_flag;
    logic         wr_ie;
    logic         mapped;
    logic         new_en;
    logic [3:0]   wkey;
    logic [15:0]  limit;
    logic [31:0]  rdata;

    function automatic logic [15:0] interval_limit(input logic [1:0] sel);
        logic [15:0] lim;
        lim = INT_LIMIT_0;
        unique case (sel)
            2'h0: lim = INT_LIMIT_0;
            2'h1: lim = INT_LIMIT_1;
            2'h2: lim = INT_LIMIT_2;
            2'h3: lim = INT_LIMIT_3;
        endcase
        return lim;
    endfunction

    always_comb begin
        st_next = st_reg;
        // The slow clock is treated as a pin and sampled, not used as a clock.
        st_next.sync1 = ls_osc_in;
        st_next.sync2 = st_reg.sync1;
        st_next.sync3 = st_reg.sync2;
        edge_any = (st_reg.sync2 == st_reg.sync3)
                   && (st_reg.sync3 != st_reg.lvl);
        tick = edge_any && st_reg.sync3;
        if (edge_any) begin
            st_next.lvl = st_reg.sync3;
        end

        deep = (pwr_mode == WDIT_DEEP_SLEEP)
               || (pwr_mode == WDIT_DEEPEST_SLEEP);
        may_reset = (pwr_mode == WDIT_ACTIVE)
                    || (pwr_mode == WDIT_LIGHTEST_SLEEP);
        running = st_reg.en && !deep;
        limit = interval_limit(st_reg.isel);
        expire = tick && running
                 && (({1'b0, st_reg.count} + 16'h0001) == limit);
        locked = st_reg.en && (st_reg.mode == MODE_WATCHDOG);

        // One wait state on every access keeps read data a registered value.
        take = psel && penable && !st_reg.pready;
        done = psel && penable && st_reg.pready && !st_reg.pslverr;
        mapped = (paddr == WD_CONTROL_OFFS) || (paddr == IRQ_FLAG_OFFS)
                 || (paddr == IRQ_ENABLE_OFFS) || (paddr == STATUS_OFFS);
        wr_ctrl = done && pwrite && (paddr == WD_CONTROL_OFFS);
        wr_flag = done && pwrite && (paddr == IRQ_FLAG_OFFS);
        wr_ie = done && pwrite && (paddr == IRQ_ENABLE_OFFS);
        wkey = pwdata[CTRL_KEY_MSB:CTRL_KEY_LSB];

        // The counter value itself is deliberately absent from the read map.
        rdata = RDATA_NONE;
        if (paddr == WD_CONTROL_OFFS) begin
            rdata[CTRL_KEY_MSB:CTRL_KEY_LSB] = st_reg.key;
            rdata[CTRL_EN_BIT] = st_reg.en;
            rdata[CTRL_MODE_BIT] = st_reg.mode;
            rdata[CTRL_INT_MSB:CTRL_INT_LSB] = st_reg.isel;
        end else if (paddr == IRQ_FLAG_OFFS) begin
            rdata[FLAG_BIT] = st_reg.flag;
        end else if (paddr == IRQ_ENABLE_OFFS) begin
            rdata[IRQ_EN_BIT] = st_reg.irq_en;
        end else if (paddr == STATUS_OFFS) begin
            rdata[STAT_RUN_BIT] = running;
            rdata[STAT_ARMED_BIT] = st_reg.armed;
        end
        st_next.pready = take;
        st_next.pslverr = take && !mapped;
        st_next.prdata = (take && !pwrite) ? rdata : RDATA_NONE;

        // The key window closes on the next slow clock edge of either sense.
        if (edge_any) begin
            st_next.armed = 1'b0;
        end
        if (tick && running) begin
            st_next.count = expire ? 15'h0000 : st_reg.count + 15'h0001;
            st_next.pend_rst = 1'b0;
        end

        st_next.rst_cnt = (st_reg.rst_cnt != 5'h00) ? st_reg.rst_cnt - 5'h01
                                                    : 5'h00;
        if (expire && (st_reg.mode == MODE_WATCHDOG)) begin
            if (may_reset) begin
                st_next.rst_cnt = SYS_RST_PULSE;
            end else begin
                st_next.pend_rst = 1'b1;
            end
        end
        if (st_reg.pend_rst && may_reset) begin
            st_next.rst_cnt = SYS_RST_PULSE;
            st_next.pend_rst = 1'b0;
        end

        if (wr_ctrl) begin
            st_next.isel = pwdata[CTRL_INT_MSB:CTRL_INT_LSB];
            st_next.key = wkey;
            new_en = locked ? 1'b1 : pwdata[CTRL_EN_BIT];
            st_next.en = new_en;
            if (!locked) begin
                st_next.mode = pwdata[CTRL_MODE_BIT];
            end
            if (new_en && !st_reg.en) begin
                st_next.count = 15'h0000;
            end
            // Keys are only honoured while enabled.
            if (st_reg.en) begin
                if (st_reg.mode == MODE_WATCHDOG) begin
                    if (st_reg.armed && (wkey == KEY_FIRE)) begin
                        st_next.count = 15'h0000;
                        st_next.armed = 1'b0;
                        st_next.pend_rst = 1'b0;
                    end else begin
                        st_next.armed = (wkey == KEY_ARM);
                    end
                end else if (wkey[TMR_CLR_BIT]) begin
                    st_next.count = 15'h0000;
                end
            end
        end else begin
            new_en = st_reg.en;
        end

        if (wr_ie) begin
            st_next.irq_en = pwdata[IRQ_EN_BIT];
        end
        // A timeout in the same cycle as the clearing write keeps the flag.
        if (wr_flag && pwdata[FLAG_BIT]) begin
            st_next.flag = 1'b0;
        end
        if (expire && (st_reg.mode == MODE_TIMER)) begin
            st_next.flag = 1'b1;
        end

        if (deep) begin
            st_next.count = 15'h0000;
            st_next.armed = 1'b0;
            st_next.pend_rst = 1'b0;
        end
        st_next.irq = st_next.flag && st_next.irq_en
                      && (st_next.mode == MODE_TIMER);
        st_next.sys_rst = (st_next.rst_cnt != 5'h00);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign sys_reset_out = st_reg.sys_rst;
    assign irq_out = st_reg.irq;

    sequence s_arm;
        wr_ctrl && st_reg.en && (st_reg.mode == MODE_WATCHDOG)
        && (wkey == KEY_ARM) && !deep && !edge_any;
    endsequence

    sequence s_fire;
        wr_ctrl && st_reg.en && st_reg.armed && (wkey == KEY_FIRE);
    endsequence

    property p_deep_zero;
        @(posedge clk_sys) disable iff (reset)
        deep |=> (st_reg.count == 15'h0000);
    endproperty
    a_deep_zero: assert property (p_deep_zero)
        else $error("Counter not zero after deep power mode.");

    property p_reset_off;
        @(posedge clk_sys) disable iff (reset)
        $fell(reset) |-> (!st_reg.en && !sys_reset_out);
    endproperty
    a_reset_off: assert property (p_reset_off)
        else $error("Unit not disabled after reset.");

    property p_lock_en;
        @(posedge clk_sys) disable iff (reset)
        (wr_ctrl && locked && !pwdata[CTRL_EN_BIT]) |=> st_reg.en;
    endproperty
    a_lock_en: assert property (p_lock_en)
        else $error("Watchdog was disabled by a write.");

    property p_lock_mode;
        @(posedge clk_sys) disable iff (reset)
        (wr_ctrl && locked) |=> (st_reg.mode == MODE_WATCHDOG)
            && (st_reg.isel == $past(pwdata[CTRL_INT_MSB:CTRL_INT_LSB]));
    endproperty
    a_lock_mode: assert property (p_lock_mode)
        else $error("Mode changed or interval lost while locked.");

    property p_wd_reset;
        @(posedge clk_sys) disable iff (reset)
        (expire && (st_reg.mode == MODE_WATCHDOG) && may_reset)
            |=> sys_reset_out [*8];
    endproperty
    a_wd_reset: assert property (p_wd_reset)
        else $error("Watchdog timeout gave no system reset.");

    property p_arm;
        @(posedge clk_sys) disable iff (reset)
        s_arm |=> st_reg.armed;
    endproperty
    a_arm: assert property (p_arm)
        else $error("First key did not arm the clear.");

    property p_clear;
        @(posedge clk_sys) disable iff (reset)
        s_fire |=> (st_reg.count == 15'h0000) && !st_reg.armed;
    endproperty
    a_clear: assert property (p_clear)
        else $error("Complete key sequence did not clear counter.");

    property p_no_irq_wd;
        @(posedge clk_sys) disable iff (reset)
        (st_reg.mode == MODE_WATCHDOG) |-> !irq_out;
    endproperty
    a_no_irq_wd: assert property (p_no_irq_wd)
        else $error("Interrupt raised in watchdog mode.");

    property p_timer_irq;
        @(posedge clk_sys) disable iff (reset)
        (expire && (st_reg.mode == MODE_TIMER))
            |=> st_reg.flag && (irq_out == st_reg.irq_en)
                && (st_reg.count == 15'h0000);
    endproperty
    a_timer_irq: assert property (p_timer_irq)
        else $error("Timer interval did not flag correctly.");

    property p_timer_norst;
        @(posedge clk_sys) disable iff (reset)
        $rose(sys_reset_out) |-> $past(st_reg.mode, 1) == MODE_WATCHDOG;
    endproperty
    a_timer_norst: assert property (p_timer_norst)
        else $error("System reset raised in timer mode.");

    property p_key_off;
        @(posedge clk_sys) disable iff (reset)
        (wr_ctrl && !st_reg.en && !pwdata[CTRL_EN_BIT] && !deep)
            |=> !st_reg.armed && $stable(st_reg.count);
    endproperty
    a_key_off: assert property (p_key_off)
        else $error("Key write acted while disabled.");

    property p_tmr_clr;
        @(posedge clk_sys) disable iff (reset)
        (wr_ctrl && st_reg.en && (st_reg.mode == MODE_TIMER)
            && wkey[TMR_CLR_BIT]) |=> (st_reg.count == 15'h0000);
    endproperty
    a_tmr_clr: assert property (p_tmr_clr)
        else $error("Timer clear bit did not zero counter.");

    property p_light_pend;
        @(posedge clk_sys) disable iff (reset)
        (expire && (st_reg.mode == MODE_WATCHDOG) && !may_reset && !wr_ctrl)
            |=> st_reg.pend_rst && !sys_reset_out;
    endproperty
    a_light_pend: assert property (p_light_pend)
        else $error("Light sleep timeout did not hold its reset back.");

    property p_pend_fire;
        @(posedge clk_sys) disable iff (reset)
        (st_reg.pend_rst && may_reset) |=> sys_reset_out;
    endproperty
    a_pend_fire: assert property (p_pend_fire)
        else $error("Pending reset not raised on return to active.");

    property p_hold;
        @(posedge clk_sys) disable iff (reset)
        !running |=> (st_reg.count == $past(st_reg.count))
                     || (st_reg.count == 15'h0000);
    endproperty
    a_hold: assert property (p_hold)
        else $error("Counter moved while the unit was stopped.");

    property p_step;
        @(posedge clk_sys) disable iff (reset)
        (tick && running && !expire && !wr_ctrl)
            |=> (st_reg.count == $past(st_reg.count) + 15'h0001);
    endproperty
    a_step: assert property (p_step)
        else $error("Enabled counter did not step on a slow tick.");

    property p_limit64;
        @(posedge clk_sys) disable iff (reset)
        (tick && running && (st_reg.isel == 2'h0)
            && (st_reg.count == 15'h003f)) |-> expire;
    endproperty
    a_limit64: assert property (p_limit64)
        else $error("Shortest interval did not end after 64 ticks.");

endmodule
`default_nettype wire

// [hw/wdit_pkg.sv]
// Package with register map, field layout and constants of the watchdog block.
package wdit_pkg;

    localparam int unsigned  ADDR_W           = 12;
    localparam logic [11:0]  WD_CONTROL_OFFS  = 12'h000;
    localparam logic [11:0]  IRQ_FLAG_OFFS    = 12'h004;
    localparam logic [11:0]  IRQ_ENABLE_OFFS  = 12'h008;
    localparam logic [11:0]  STATUS_OFFS      = 12'h00c;

    localparam int unsigned  CTRL_KEY_LSB     = 4;
    localparam int unsigned  CTRL_KEY_MSB     = 7;
    localparam int unsigned  CTRL_EN_BIT      = 3;
    localparam int unsigned  CTRL_MODE_BIT    = 2;
    localparam int unsigned  CTRL_INT_LSB     = 0;
    localparam int unsigned  CTRL_INT_MSB     = 1;
    localparam int unsigned  FLAG_BIT         = 0;
    localparam int unsigned  IRQ_EN_BIT       = 0;
    localparam int unsigned  STAT_RUN_BIT     = 0;
    localparam int unsigned  STAT_ARMED_BIT   = 1;
    localparam int unsigned  TMR_CLR_BIT      = 0;

    localparam logic [3:0]   KEY_ARM          = 4'ha;
    localparam logic [3:0]   KEY_FIRE         = 4'h5;
    localparam logic         MODE_WATCHDOG    = 1'b0;
    localparam logic         MODE_TIMER       = 1'b1;

    localparam logic [15:0]  INT_LIMIT_0      = 16'h0040;
    localparam logic [15:0]  INT_LIMIT_1      = 16'h0200;
    localparam logic [15:0]  INT_LIMIT_2      = 16'h2000;
    localparam logic [15:0]  INT_LIMIT_3      = 16'h8000;

    localparam logic [4:0]   SYS_RST_PULSE    = 5'h10;
    localparam logic [31:0]  RDATA_NONE       = 32'h0000_0000;

    typedef enum logic [2:0] {
        WDIT_ACTIVE          = 3'b000,
        WDIT_LIGHTEST_SLEEP  = 3'b001,
        WDIT_LIGHT_SLEEP     = 3'b010,
        WDIT_DEEP_SLEEP      = 3'b011,
        WDIT_DEEPEST_SLEEP   = 3'b100
    } wdit_pmode_t;

    typedef struct packed {
        logic         sync1;
        logic         sync2;
        logic         sync3;
        logic         lvl;
        logic [14:0]  count;
        logic         en;
        logic         mode;
        logic [1:0]   isel;
        logic [3:0]   key;
        logic         armed;
        logic         pend_rst;
        logic         flag;
        logic         irq_en;
        logic         irq;
        logic [4:0]   rst_cnt;
        logic         sys_rst;
        logic         pready;
        logic         pslverr;
        logic [31:0]  prdata;
    } wdit_state_t;

endpackage

// [test/wdit_osc_model.sv]
// Slow oscillator model that feeds the watchdog counter pin.
`timescale 1ns/10ps
`default_nettype none
module wdit_osc_model #(
    parameter real HALF_NS = 123.2
) (
    output logic osc
);
    // Free running; the half period keeps rising edges off rising clock edges.
    initial begin
        osc = 1'b0;
        forever #(HALF_NS) osc = ~osc;
    end
endmodule
`default_nettype wire

// [test/watchdog_interval_timer_tb_top.sv]
// Self-checking testbench of the watchdog and interval timer.
`timescale 1ns/10ps
`default_nettype none
module watchdog_interval_timer_tb_top
    import wdit_pkg::*;
;
    localparam int T0 = 1577;
    logic        clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic [2:0]  pwr_mode = 3'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, sys_reset_out, irq_out, osc;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    int          err_count = 0, compares = 0, rst_cyc = 0, n, a;

    always #5 clk_sys = ~clk_sys;
    wdit_osc_model u_osc (.osc(osc));
    wdit_top u_dut (.clk_sys(clk_sys), .reset(reset), .ls_osc_in(osc),
        .pwr_mode(pwr_mode), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .sys_reset_out(sys_reset_out), .irq_out(irq_out));

    task automatic chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask

    task automatic results();
        if (err_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // The note is queued by the driver; the monitor below checks it.
    task automatic apb(input logic wr, input logic [11:0] ad,
                       input logic [31:0] d, input logic [31:0] x,
                       input logic er, input logic keep);
        int k;
        k = 0;
        exp_q.push_back({wr, er, x});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 50);
        chk(k < 50, "apb no ready");
        penable <= 1'b0;
        // One idle edge after a release, so psel never toggles in one step.
        if (!keep) begin
            psel <= 1'b0;
            @(posedge clk_sys);
        end
    endtask

    task automatic wr(input logic [11:0] ad, input logic [7:0] d);
        apb(1'b1, ad, {$urandom() & 32'hffffff00} | d, 32'h0, 1'b0, 1'b0);
    endtask

    task automatic rd(input logic [11:0] ad, input logic [31:0] x);
        apb(1'b0, ad, 32'h0, x, 1'b0, 1'b0);
    endtask

    // Two writes, or three with a middle key, aligned inside one half slow period.
    task automatic clear_seq(input logic [3:0] mid);
        @(posedge osc);
        repeat (5 + ($urandom() % 2)) @(posedge clk_sys);
        apb(1'b1, WD_CONTROL_OFFS, 32'ha8, 32'h0, 1'b0, 1'b1);
        if (mid != 4'h0) apb(1'b1, WD_CONTROL_OFFS, {mid, 4'h8}, 0, 0, 1);
        apb(1'b1, WD_CONTROL_OFFS, 32'h58, 32'h0, 1'b0, 1'b0);
    endtask

    task automatic wait_hi(input logic irq, input int mx, output int k);
        k = 0;
        while ((irq ? irq_out : sys_reset_out) !== 1'b1 && k < mx) begin
            @(posedge clk_sys);
            k++;
        end
    endtask

    task automatic do_reset();
        reset <= 1'b1;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
    endtask

    always @(posedge clk_sys) begin
        if (sys_reset_out === 1'b1) rst_cyc <= rst_cyc + 1;
        if (psel && penable && pready === 1'b1) begin
            e = exp_q.pop_front();
            chk(pslverr === e[32] && (e[33] || prdata === e[31:0]), "apb");
        end
    end

    initial begin
        repeat (30000) @(posedge clk_sys);
        err_count++;
        results();
    end

    initial begin
        void'($urandom(32'he469));
        do_reset();
        rd(WD_CONTROL_OFFS, 32'h0);
        rd(STATUS_OFFS, 32'h0);
        apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1, 1'b0);
        wr(WD_CONTROL_OFFS, 8'h08);
        wait_hi(1'b0, T0 + 60, n);
        chk(n > T0 - 60 && n < T0 + 60, "watchdog timeout");
        a = rst_cyc;
        repeat (30) @(posedge clk_sys);
        chk(rst_cyc-a == SYS_RST_PULSE && irq_out === 0, "pulse");
        wr(WD_CONTROL_OFFS, 8'h05);
        rd(WD_CONTROL_OFFS, 32'h09);
        wr(WD_CONTROL_OFFS, 8'h08);
        clear_seq(4'h0);
        a = rst_cyc;
        repeat (6) begin
            repeat (700) @(posedge clk_sys);
            clear_seq(4'h0);
        end
        chk(rst_cyc == a, "cleared watchdog fired");
        clear_seq(4'h3);
        wait_hi(1'b0, T0 + 60, n);
        chk(n < T0 + 60, "bad key kept counter");
        repeat (1000) @(posedge clk_sys);
        pwr_mode <= 3'h3;
        repeat (200) @(posedge clk_sys);
        rd(STATUS_OFFS, 32'h0);
        pwr_mode <= 3'h1;
        wait_hi(1'b0, T0 + 60, n);
        chk(n > T0 - 60 && n < T0 + 60, "deep sleep restart");
        repeat (30) @(posedge clk_sys);
        pwr_mode <= 3'h2;
        a = rst_cyc;
        // Wake inside the slow tick that follows the light sleep timeout.
        repeat (T0 - 20) @(posedge clk_sys);
        chk(rst_cyc == a, "reset in light sleep");
        pwr_mode <= 3'h0;
        wait_hi(1'b0, 4, n);
        chk(n < 4, "pending reset");
        do_reset();
        for (int i = 0; i < 4; i++) begin
            wr(WD_CONTROL_OFFS, 8'h04 | i[7:0]);
            rd(WD_CONTROL_OFFS, 32'h04 | i);
        end
        wr(IRQ_ENABLE_OFFS, 8'h01);
        a = rst_cyc;
        wr(WD_CONTROL_OFFS, 8'h0c);
        wait_hi(1'b1, T0 + 60, n);
        chk(n > T0 - 60 && n < T0 + 60, "timer event");
        rd(IRQ_FLAG_OFFS, 32'h1);
        wr(IRQ_FLAG_OFFS, 8'h01);
        @(posedge clk_sys);
        chk(irq_out === 1'b0, "flag clear");
        wait_hi(1'b1, T0 + 60, n);
        chk(n > T0 - 80 && n < T0 + 60, "periodic event");
        wr(IRQ_FLAG_OFFS, 8'h01);
        repeat (700) @(posedge clk_sys);
        wr(WD_CONTROL_OFFS, 8'h1c);
        wait_hi(1'b1, T0 + 60, n);
        chk(n > T0 - 60 && n < T0 + 60, "key clear");
        wr(IRQ_FLAG_OFFS, 8'h01);
        wr(WD_CONTROL_OFFS, 8'h04);
        wr(IRQ_ENABLE_OFFS, 8'h00);
        repeat (2 * T0) @(posedge clk_sys);
        rd(IRQ_FLAG_OFFS, 32'h0);
        wr(WD_CONTROL_OFFS, 8'h0c);
        repeat (T0 + 60) @(posedge clk_sys);
        chk(irq_out === 1'b0, "masked interrupt");
        rd(IRQ_FLAG_OFFS, 32'h1);
        chk(rst_cyc == a, "timer reset");
        results();
    end
endmodule
`default_nettype wire
